// ===== boundary_scan_tap_test.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
`include "bst_consts.svh"

module boundary_scan_tap_test;
	import bst_pkg::*;

	localparam logic [`BST_ID_W-1:0] TB_ID = 32'h1234_5679; // Arbitrary code, bit 0 set
	localparam int                   DR_N  = 112;

	logic                  clk_sys_in;
	logic                  reset_n_in;
	bst_pins_t             pins;
	logic [`BST_BND_W-1:0] io_ring;
	logic                  tdo;
	logic                  tdo_oe;
	int                    n_fail;
	int                    n_compared;
	logic [2:0]            row_ir [5];
	logic [DR_N-1:0]       row_exp [5];
	logic [`BST_BND_W-1:0] row_ring [5];
	logic [DR_N-1:0]       dout;

	bst_tap #(.ID_CODE(TB_ID)) i_bst_tap (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .pins_in(pins),
		.io_ring_in(io_ring), .tdo_out(tdo), .tdo_oe_out(tdo_oe));
	bst_ctl_model i_bst_ctl_model (.clk_in(clk_sys_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .pins_out(pins));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [DR_N-1:0] seen, input logic [DR_N-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Scan n bits LSB first from run-test/idle and back; unused high bits read as ones
	task automatic scan(input logic ir_path, input int n, input logic [DR_N-1:0] din, output logic [DR_N-1:0] got);
		got = '1;
		i_bst_ctl_model.move(1'b1);
		if (ir_path) begin
			i_bst_ctl_model.move(1'b1);
		end
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.move(1'b0);
		for (int k = 0; k < n; k++) begin
			i_bst_ctl_model.step(k == n - 1, din[k]);
			got[k] = i_bst_ctl_model.tdo_b;
			check(DR_N'(i_bst_ctl_model.tdo_a), DR_N'(i_bst_ctl_model.tdo_b));
			check(DR_N'(i_bst_ctl_model.oe_b), DR_N'(1'b1));
		end
		i_bst_ctl_model.move(1'b1);
		check(DR_N'(i_bst_ctl_model.oe_b), '0);
		i_bst_ctl_model.move(1'b0);
	endtask

	task automatic load_ir(input logic [2:0] code);
		logic [DR_N-1:0] got;
		scan(1'b1, 3, DR_N'(code), got);
		check(got, {{109{1'b1}}, 3'b001});
	endtask

	// Power-up or TAP reset must leave the identification path selected
	task automatic id_after_reset();
		i_bst_ctl_model.move(1'b0);
		scan(1'b0, DR_N, '1, dout);
		check(dout, row_exp[0]);
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	// About 10k clocks of scanning expected; four times that allowed
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		n_fail++;
		close_out();
	end

	initial begin
		reset_n_in = 1'b0;
		io_ring    = '0;
		row_ring   = '{'0, '0, {5'h15, {13{8'hC3}}}, {5'h0A, {13{8'h3C}}}, '0};
		n_fail     = 0;
		n_compared = 0;
		row_ir     = '{`BST_IR_IDCODE, `BST_IR_BYPASS, `BST_IR_EXTEST, `BST_IR_SAMPLE, 3'h2};
		row_exp    = '{{{80{1'b1}}, TB_ID}, {{111{1'b1}}, 1'b0}, {3'b111, row_ring[2]}, {3'b111, row_ring[3]},
			{{111{1'b1}}, 1'b0}};
		repeat (6) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		id_after_reset();
		$display("power-up test done");
		// Ordinary rows: instruction in, scanned data path out
		for (int r = 0; r < 5; r++) begin
			io_ring <= row_ring[r]; // Ring differs between the extest and sample rows so a stale capture shows
			load_ir(row_ir[r]);
			scan(1'b0, DR_N, '1, dout);
			check(dout, row_exp[r]);
			$display("row %0d test done", r);
		end
		// Five high TMS rises undo a bypass instruction
		load_ir(`BST_IR_BYPASS);
		i_bst_ctl_model.tap_reset();
		i_bst_ctl_model.move(1'b0);
		scan(1'b0, DR_N, '1, dout);
		check(dout, row_exp[0]);
		$display("tms reset test done");
		// Identification scan paused halfway: exit, pause, exit and back to shift
		dout = '1;
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.move(1'b0);
		for (int k = 0; k < `BST_ID_W; k++) begin
			if (k == 16) begin
				i_bst_ctl_model.move(1'b0);
				check(DR_N'(i_bst_ctl_model.oe_b), '0);
				i_bst_ctl_model.move(1'b0);
				i_bst_ctl_model.move(1'b1);
				i_bst_ctl_model.move(1'b0);
			end
			i_bst_ctl_model.step(k == 15 || k == `BST_ID_W - 1, 1'b1);
			dout[k] = i_bst_ctl_model.tdo_b;
		end
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b0);
		check(dout, {{80{1'b1}}, TB_ID});
		$display("data pause test done");
		// Bypass shifted in with a pause in the instruction branch
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.step(1'b0, 1'b1);
		i_bst_ctl_model.step(1'b1, 1'b1);
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b0);
		i_bst_ctl_model.step(1'b1, 1'b1);
		i_bst_ctl_model.move(1'b1);
		i_bst_ctl_model.move(1'b0);
		scan(1'b0, DR_N, '1, dout);
		check(dout, row_exp[1]);
		$display("instruction pause test done");
		// Reset pin mid-run with bypass loaded, test clock idle throughout
		reset_n_in <= 1'b0;
		repeat (6) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		id_after_reset();
		$display("pin reset test done");
		close_out();
	end
endmodule

// ===== bst_consts.svh
// Constants of the boundary-scan test port: widths, codes and counts
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ----------------------------------------------------------------
// Serial register widths
// ----------------------------------------------------------------
`define BST_IR_W        3
`define BST_ID_W        32
`define BST_BND_W       109

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define BST_IR_EXTEST   3'h0
`define BST_IR_IDCODE   3'h1
`define BST_IR_SAMPLE   3'h4
`define BST_IR_BYPASS   3'h7
`define BST_IR_CAPTURE  3'h1

// ----------------------------------------------------------------
// Reset and timing values
// ----------------------------------------------------------------
`define BST_TMS_RESET_CNT 3'h5
`define BST_TMS_LAST_CNT  3'h4
`define BST_CNT_ZERO      3'h0
`define BST_CNT_ONE       3'h1
`define BST_BIT_ZERO      1'h0
`define BST_BIT_ONE       1'h1
`define BST_SYNC_ZERO     3'h0
`define BST_TCK_NS        400
`define BST_SYS_NS        50

`endif

// ===== bst_ctl_model.sv
// Behavioural external test controller driving the test pins
`timescale 1ns/1ns

module bst_ctl_model (
	// Clock
	input  wire logic          clk_in,
	// Serial data back from the port
	input  wire logic          tdo_in,
	input  wire logic          tdo_oe_in,
	// Test pins
	output bst_pkg::bst_pins_t pins_out
);
	import bst_pkg::*;

	logic tdo_a;
	logic tdo_b;
	logic oe_b;

	// ----------------------------------------------------------------
	// Pin sequencing
	// ----------------------------------------------------------------
	// Test clock idles low between frames
	initial begin
		pins_out = '0;
	end

	// One 400 ns period: TMS/TDI set 4 clk before the rise, held 4 clk after
	// TDO is read twice while TCK is high, well after the previous fall has settled
	task automatic step(input logic tms, input logic tdi);
		pins_out.tms <= tms;
		pins_out.tdi <= tdi;
		repeat (4) @(posedge clk_in);
		pins_out.tck <= 1'b1;
		@(posedge clk_in);
		tdo_a = tdo_in;
		@(posedge clk_in);
		tdo_b = tdo_in;
		oe_b  = tdo_oe_in;
		pins_out.tck <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	// Mode-only step; TDI flips so a stale level never passes for data
	task automatic move(input logic tms);
		step(tms, ~pins_out.tdi);
	endtask

	// Five rises with TMS high, the only reset path besides power-up
	task automatic tap_reset();
		repeat (5) move(1'b1);
	endtask
endmodule

// ===== bst_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "bst_consts.svh"

module bst_pin_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	genvar g;

	// ----------------------------------------------------------------
	// Per-bit chain; the first stage feeds only the second
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			// Level moves only once stages two and three agree
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					s1           <= `BST_BIT_ZERO;
					s2           <= `BST_BIT_ZERO;
					s3           <= `BST_BIT_ZERO;
					level_out[g] <= `BST_BIT_ZERO;
				end else begin
					s1 <= pin_in[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						level_out[g] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule

// ===== bst_pkg.sv
// Types shared by the boundary-scan test port
package bst_pkg;

	// ----------------------------------------------------------------
	// Controller states, Gray steps in the order listed
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		BST_TLR   = 4'h0,
		BST_RTI   = 4'h1,
		BST_SELDR = 4'h3,
		BST_CAPDR = 4'h2,
		BST_SHDR  = 4'h6,
		BST_EX1DR = 4'h7,
		BST_PDR   = 4'h5,
		BST_EX2DR = 4'h4,
		BST_UPDR  = 4'hC,
		BST_SELIR = 4'hD,
		BST_CAPIR = 4'hF,
		BST_SHIR  = 4'hE,
		BST_EX1IR = 4'hA,
		BST_PIR   = 4'hB,
		BST_EX2IR = 4'h9,
		BST_UPIR  = 4'h8
	} bst_state_t;

	// ----------------------------------------------------------------
	// Test pins from the external controller
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bst_pins_t;

endpackage

// ===== bst_tap.sv
// Boundary-scan test access port sampled by the system clock
//
// Contract
// - Only a reduced instruction set is decoded: extest, idcode, sample and bypass.
// - TMS and TDI are taken at each rising edge of the test clock.
// - TDO changes only at a falling edge of the test clock.
// - The controller steers the state machine with TMS alone, one step per rising edge.
// - The register between TDI and TDO is chosen from state and current instruction.
// - Five rising edges with TMS high put the port in test-logic-reset.
// - Power-up reset puts the state machine in test-logic-reset without any clock.
// - The 3-bit instruction register is loaded with idcode while in test-logic-reset.
// - A one-bit bypass register passes scan data with minimal delay.
// - With idcode loaded, capture-DR loads a fixed 32-bit code that shift-DR sends out.
// - A 109-bit boundary register captures the I/O ring and shifts it out.
`timescale 1ns/1ns
`include "bst_consts.svh"

module bst_tap #(
	parameter logic [`BST_ID_W-1:0] ID_CODE = 32'h0A5C_3001 // Arbitrary code, bit 0 set
) (
	// Clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_n_in,
	// Test pins and I/O ring
	input  wire bst_pkg::bst_pins_t    pins_in,
	input  wire logic [`BST_BND_W-1:0] io_ring_in,
	output logic                       tdo_out,
	output logic                       tdo_oe_out
);
	import bst_pkg::*;

	// Test clock is sampled, so it must stay far below the system rate
	localparam int TCK_SYS_RATIO = `BST_TCK_NS / `BST_SYS_NS;

	logic                  rst_a;
	logic                  rst_n;
	logic [2:0]            pin_lvl;
	bst_pins_t             p;
	logic                  tck_q;
	bst_state_t            state;
	bst_state_t            next_state;
	logic [`BST_IR_W-1:0]  ir;
	logic [`BST_IR_W-1:0]  ir_sr;
	logic                  bypass;
	logic [`BST_ID_W-1:0]  id_sr;
	logic [`BST_BND_W-1:0] bnd_sr;
	logic [2:0]            tms_hi_cnt;

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	// Two-stage release so the whole port leaves reset on one edge
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_a <= `BST_BIT_ZERO;
			rst_n <= `BST_BIT_ZERO;
		end else begin
			rst_a <= `BST_BIT_ONE;
			rst_n <= rst_a;
		end
	end

	bst_pin_sync #(
		.W (3)
	) u_sync (
		.clk_in    (clk_sys_in),
		.rst_n_in  (rst_n),
		.pin_in    (pins_in),
		.level_out (pin_lvl)
	);

	assign p = pin_lvl;

	// ----------------------------------------------------------------
	// Test clock edges and register selection
	// ----------------------------------------------------------------
	wire tck_rise = p.tck & ~tck_q;
	wire tck_fall = ~p.tck & tck_q;
	wire sel_bnd  = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE);
	wire sel_id   = (ir == `BST_IR_IDCODE);
	wire sel_byp  = ~sel_bnd & ~sel_id; // Unused codes fall to bypass
	wire dr_lsb   = sel_bnd ? bnd_sr[0] : (sel_id ? id_sr[0] : bypass);
	wire in_shir  = (state == BST_SHIR);
	wire in_shdr  = (state == BST_SHDR);

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tck_q <= `BST_BIT_ZERO;
		end else begin
			tck_q <= p.tck;
		end
	end

	// ----------------------------------------------------------------
	// Controller next state
	// ----------------------------------------------------------------
	// Standard sixteen-state walk steered by TMS
	always_comb begin
		case (state)
			BST_TLR:   next_state = p.tms ? BST_TLR   : BST_RTI;
			BST_RTI:   next_state = p.tms ? BST_SELDR : BST_RTI;
			BST_SELDR: next_state = p.tms ? BST_SELIR : BST_CAPDR;
			BST_CAPDR: next_state = p.tms ? BST_EX1DR : BST_SHDR;
			BST_SHDR:  next_state = p.tms ? BST_EX1DR : BST_SHDR;
			BST_EX1DR: next_state = p.tms ? BST_UPDR  : BST_PDR;
			BST_PDR:   next_state = p.tms ? BST_EX2DR : BST_PDR;
			BST_EX2DR: next_state = p.tms ? BST_UPDR  : BST_SHDR;
			BST_UPDR:  next_state = p.tms ? BST_SELDR : BST_RTI;
			BST_SELIR: next_state = p.tms ? BST_TLR   : BST_CAPIR;
			BST_CAPIR: next_state = p.tms ? BST_EX1IR : BST_SHIR;
			BST_SHIR:  next_state = p.tms ? BST_EX1IR : BST_SHIR;
			BST_EX1IR: next_state = p.tms ? BST_UPIR  : BST_PIR;
			BST_PIR:   next_state = p.tms ? BST_EX2IR : BST_PIR;
			BST_EX2IR: next_state = p.tms ? BST_UPIR  : BST_SHIR;
			BST_UPIR:  next_state = p.tms ? BST_SELDR : BST_RTI;
			default:   next_state = BST_TLR;
		endcase
	end

	// Power-up lands in test-logic-reset with no test clock
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= BST_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	// Shift on rise, update on fall of update-IR as the standard does
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ir    <= `BST_IR_IDCODE;
			ir_sr <= `BST_IR_CAPTURE;
		end else begin
			if (state == BST_TLR) begin
				ir <= `BST_IR_IDCODE;
			end else if (tck_fall && state == BST_UPIR) begin
				ir <= ir_sr;
			end
			if (tck_rise && state == BST_CAPIR) begin
				ir_sr <= `BST_IR_CAPTURE;
			end else if (tck_rise && in_shir) begin
				ir_sr <= {p.tdi, ir_sr[`BST_IR_W-1:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	// Only the selected register captures or shifts
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			bypass <= `BST_BIT_ZERO;
			id_sr  <= '0;
			bnd_sr <= '0;
		end else if (tck_rise && state == BST_CAPDR) begin
			if (sel_byp) bypass <= `BST_BIT_ZERO;
			if (sel_id)  id_sr  <= ID_CODE;
			if (sel_bnd) bnd_sr <= io_ring_in;
		end else if (tck_rise && in_shdr) begin
			if (sel_byp) bypass <= p.tdi;
			if (sel_id)  id_sr  <= {p.tdi, id_sr[`BST_ID_W-1:1]};
			if (sel_bnd) bnd_sr <= {p.tdi, bnd_sr[`BST_BND_W-1:1]};
		end
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	// Moves on fall so it is steady across the next rise
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tdo_out    <= `BST_BIT_ZERO;
			tdo_oe_out <= `BST_BIT_ZERO;
		end else if (tck_fall) begin
			tdo_oe_out <= in_shir | in_shdr;
			if (in_shir) begin
				tdo_out <= ir_sr[0];
			end else if (in_shdr) begin
				tdo_out <= dr_lsb;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Counts consecutive rises with TMS high, saturating at the limit
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tms_hi_cnt <= `BST_CNT_ZERO;
		end else if (tck_rise) begin
			if (!p.tms) begin
				tms_hi_cnt <= `BST_CNT_ZERO;
			end else if (tms_hi_cnt != `BST_TMS_RESET_CNT) begin
				tms_hi_cnt <= 3'(tms_hi_cnt + `BST_CNT_ONE);
			end
		end
	end

	sequence s_cap_id;
		tck_rise && state == BST_CAPDR && sel_id;
	endsequence

	sequence s_shift_byp;
		tck_rise && in_shdr && sel_byp;
	endsequence

	sequence s_cap_bnd;
		tck_rise && state == BST_CAPDR && sel_bnd;
	endsequence

	chk_fsm_tms_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		tck_rise |=> state == $past(next_state))
		else $error("state did not follow TMS");
	chk_state_on_rise: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		$changed(state) |-> $past(tck_rise))
		else $error("state moved without a rising test clock");
	chk_tdo_on_fall: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		$changed(tdo_out) |-> $past(tck_fall))
		else $error("TDO moved without a falling test clock");
	chk_five_tms_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(tck_rise && p.tms && tms_hi_cnt >= `BST_TMS_LAST_CNT) |=> state == BST_TLR)
		else $error("five TMS highs did not reset the port");
	chk_tlr_idcode: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state == BST_TLR |=> ir == `BST_IR_IDCODE)
		else $error("instruction not idcode in test-logic-reset");
	chk_id_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_cap_id |=> id_sr == ID_CODE)
		else $error("identification code not captured");
	chk_bypass_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_shift_byp |=> bypass == $past(p.tdi))
		else $error("bypass bit did not take TDI");
	chk_bnd_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_cap_bnd |=> bnd_sr == $past(io_ring_in))
		else $error("boundary register did not capture the ring");
	chk_tdo_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(tck_fall && in_shdr) |=> tdo_out == $past(dr_lsb) && tdo_oe_out)
		else $error("TDO not from the selected data register");

endmodule
